// file: hdl/display_ram.sv
/*
 * Display memory: one synchronous write port and one read port whose
 * data come out of a register. Assumes both ports share one clock.
 */
module display_ram (
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [lcd_cmd_pkg::MEM_AW-1:0] waddr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [lcd_cmd_pkg::MEM_AW-1:0] raddr_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [0:(1 << lcd_cmd_pkg::MEM_AW)-1];

	// No reset: the host is expected to clear both layers after power-up.
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule : display_ram

// file: hdl/lcd_cmd_decoder.sv
/*
 * Command decoder of the LCD controller: display switch, cursor address,
 * cursor shape, cursor direction and display memory write commands.
 * Assumes the host byte strobe comes from logic on the same clock.
 */
module lcd_cmd_decoder (
	input wire logic REF_CLK_I,
	input wire logic RST_N_I,
	input wire logic BYTE_VALID_I,
	input wire logic BYTE_IS_CMD_I,
	input wire logic [7:0] BYTE_DATA_I,
	input wire logic [15:0] LINE_PITCH_I,
	input wire logic REG_RD_I,
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [15:0] SCAN_ADDR_I,
	output logic [7:0] REG_DATA_O,
	output logic DISP_ENABLE_O,
	output logic [7:0] ATTR_O,
	output logic [15:0] CURSOR_ADDR_O,
	output logic [3:0] CURSOR_WIDTH_O,
	output logic [3:0] CURSOR_HEIGHT_O,
	output logic CURSOR_BLOCK_O,
	output logic [1:0] SHIFT_DIR_O,
	output logic [15:0] BLOCK1_START_O,
	output logic [15:0] BLOCK2_START_O,
	output logic [7:0] SCAN_DATA_O
);
	lcd_cmd_pkg::host_byte_t hb;
	lcd_cmd_pkg::dec_state_t state, next_state;
	lcd_cmd_pkg::cursor_shape_t shape, next_shape;
	logic [7:0] disp_en, next_disp_en;
	logic [7:0] attr, next_attr;
	logic [1:0] dir, next_dir;
	logic [15:0] cursor, next_cursor;
	logic [15:0] block1_start, block2_start;
	logic [7:0] rd_data, next_rd_data;
	logic param_take;
	logic cmd_take;
	logic mem_we;
	logic [15:0] step;

	assign hb = '{is_cmd: BYTE_IS_CMD_I, data: BYTE_DATA_I};
	assign cmd_take = BYTE_VALID_I && hb.is_cmd;
	assign param_take = BYTE_VALID_I && !hb.is_cmd;
	assign mem_we = param_take && (state == lcd_cmd_pkg::ST_MEM_WRITE);

	// The down and up steps use the line pitch set up by the system setup
	// logic, so a pitch change takes effect on the next written byte.
	always_comb begin
		case (dir)
			lcd_cmd_pkg::DIR_RIGHT: step = lcd_cmd_pkg::ONE_STEP;
			lcd_cmd_pkg::DIR_LEFT: step = -lcd_cmd_pkg::ONE_STEP;
			lcd_cmd_pkg::DIR_UP: step = -LINE_PITCH_I;
			lcd_cmd_pkg::DIR_DOWN: step = LINE_PITCH_I;
			default: step = lcd_cmd_pkg::ONE_STEP;
		endcase
	end

	always_comb begin
		next_state = state;
		next_disp_en = disp_en;
		next_attr = attr;
		next_shape = shape;
		next_dir = dir;
		next_cursor = cursor;
		if (cmd_take) begin
			// Any command byte ends the previous parameter run.
			case (hb.data)
				lcd_cmd_pkg::CMD_DISP_OFF: begin
					next_disp_en[lcd_cmd_pkg::DISP_ENABLE_BIT] = 1'b0;
					next_state = lcd_cmd_pkg::ST_SWITCH_P1;
				end
				lcd_cmd_pkg::CMD_DISP_ON: begin
					next_disp_en[lcd_cmd_pkg::DISP_ENABLE_BIT] = 1'b1;
					next_state = lcd_cmd_pkg::ST_SWITCH_P1;
				end
				lcd_cmd_pkg::CMD_CURSOR_LOAD: begin
					next_state = lcd_cmd_pkg::ST_CURSOR_LO;
				end
				lcd_cmd_pkg::CMD_CURSOR_SHAPE: begin
					next_state = lcd_cmd_pkg::ST_SHAPE_W;
				end
				lcd_cmd_pkg::CMD_MEM_WRITE: begin
					next_state = lcd_cmd_pkg::ST_MEM_WRITE;
				end
				default: begin
					next_state = lcd_cmd_pkg::ST_IDLE;
					if ((hb.data & lcd_cmd_pkg::CMD_DIR_MASK) ==
					    lcd_cmd_pkg::CMD_DIR_BASE) begin
						next_dir = hb.data[1:0];
					end
				end
			endcase
		end else if (param_take) begin
			case (state)
				lcd_cmd_pkg::ST_SWITCH_P1: begin
					// Visibility and flashing are decoded by the panel
					// side from these fields.
					next_attr = hb.data;
					next_state = lcd_cmd_pkg::ST_IDLE;
				end
				lcd_cmd_pkg::ST_CURSOR_LO: begin
					next_cursor[7:0] = hb.data;
					next_state = lcd_cmd_pkg::ST_CURSOR_HI;
				end
				lcd_cmd_pkg::ST_CURSOR_HI: begin
					next_cursor[15:8] = hb.data;
					next_state = lcd_cmd_pkg::ST_IDLE;
				end
				lcd_cmd_pkg::ST_SHAPE_W: begin
					next_shape.width = hb.data[lcd_cmd_pkg::SIZE_W-1:0];
					next_state = lcd_cmd_pkg::ST_SHAPE_H;
				end
				lcd_cmd_pkg::ST_SHAPE_H: begin
					next_shape.height = hb.data[lcd_cmd_pkg::SIZE_W-1:0];
					next_shape.block_style =
					    hb.data[lcd_cmd_pkg::CURSOR_STYLE_BIT];
					next_state = lcd_cmd_pkg::ST_IDLE;
				end
				lcd_cmd_pkg::ST_MEM_WRITE: begin
					// Stay here so runs of any length are accepted.
					next_cursor = cursor + step;
				end
				default: begin
					// Surplus parameters are dropped silently.
					next_state = lcd_cmd_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state <= lcd_cmd_pkg::ST_IDLE;
			disp_en <= lcd_cmd_pkg::REG_RESET;
			attr <= lcd_cmd_pkg::REG_RESET;
			shape <= '0;
			dir <= lcd_cmd_pkg::DIR_RIGHT;
			cursor <= lcd_cmd_pkg::CURSOR_RESET;
		end else begin
			state <= next_state;
			disp_en <= next_disp_en;
			attr <= next_attr;
			shape <= next_shape;
			dir <= next_dir;
			cursor <= next_cursor;
		end
	end

	// The start pairs are not loaded here; they only hold their layout.
	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			block1_start <= lcd_cmd_pkg::BLOCK1_START_RESET;
			block2_start <= lcd_cmd_pkg::BLOCK2_START_RESET;
		end else begin
			block1_start <= block1_start;
			block2_start <= block2_start;
		end
	end

	always_comb begin
		next_rd_data = rd_data;
		if (REG_RD_I) begin
			case (REG_ADDR_I)
				lcd_cmd_pkg::OFS_DISP_ENABLE: next_rd_data = disp_en;
				lcd_cmd_pkg::OFS_ATTRIBUTE: next_rd_data = attr;
				lcd_cmd_pkg::OFS_BLOCK1_LO: next_rd_data = block1_start[7:0];
				lcd_cmd_pkg::OFS_BLOCK1_HI: next_rd_data = block1_start[15:8];
				lcd_cmd_pkg::OFS_BLOCK2_LO: next_rd_data = block2_start[7:0];
				lcd_cmd_pkg::OFS_BLOCK2_HI: next_rd_data = block2_start[15:8];
				lcd_cmd_pkg::OFS_CURSOR_WIDTH: next_rd_data = {4'h0, shape.width};
				lcd_cmd_pkg::OFS_CURSOR_HEIGHT:
					next_rd_data = {shape.block_style, 3'h0, shape.height};
				lcd_cmd_pkg::OFS_SHIFT_DIR: next_rd_data = {6'h00, dir};
				lcd_cmd_pkg::OFS_CURSOR_LO: next_rd_data = cursor[7:0];
				lcd_cmd_pkg::OFS_CURSOR_HI: next_rd_data = cursor[15:8];
				default: next_rd_data = lcd_cmd_pkg::REG_RESET;
			endcase
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rd_data <= lcd_cmd_pkg::REG_RESET;
		end else begin
			rd_data <= next_rd_data;
		end
	end

	display_ram u_ram (
		.clk_i(REF_CLK_I),
		.we_i(mem_we),
		.waddr_i(cursor),
		.wdata_i(hb.data),
		.raddr_i(SCAN_ADDR_I),
		.rdata_o(SCAN_DATA_O)
	);

	assign REG_DATA_O = rd_data;
	assign DISP_ENABLE_O = disp_en[lcd_cmd_pkg::DISP_ENABLE_BIT];
	assign ATTR_O = attr;
	assign CURSOR_ADDR_O = cursor;
	assign CURSOR_WIDTH_O = shape.width;
	assign CURSOR_HEIGHT_O = shape.height;
	assign CURSOR_BLOCK_O = shape.block_style;
	assign SHIFT_DIR_O = dir;
	assign BLOCK1_START_O = block1_start;
	assign BLOCK2_START_O = block2_start;

	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (!RST_N_I);

	a_display_off: assert property (
		cmd_take && hb.data == lcd_cmd_pkg::CMD_DISP_OFF
		|=> !DISP_ENABLE_O)
		else $error("display did not turn off after 58h");
	a_display_on: assert property (
		cmd_take && hb.data == lcd_cmd_pkg::CMD_DISP_ON
		|=> DISP_ENABLE_O)
		else $error("display did not turn on after 59h");
	// Keyed on the decoder state, so any spacing of the bytes is covered.
	a_attr_load: assert property (
		state == lcd_cmd_pkg::ST_SWITCH_P1 && param_take
		|=> ATTR_O == $past(BYTE_DATA_I))
		else $error("attribute not loaded from first parameter");
	a_cursor_low: assert property (
		state == lcd_cmd_pkg::ST_CURSOR_LO && param_take
		|=> CURSOR_ADDR_O[7:0] == $past(BYTE_DATA_I))
		else $error("cursor low byte not taken from first parameter");
	a_cursor_pair: assert property (
		state == lcd_cmd_pkg::ST_CURSOR_HI && param_take
		|=> CURSOR_ADDR_O ==
		{$past(BYTE_DATA_I), $past(CURSOR_ADDR_O[7:0])})
		else $error("cursor address pair loaded in wrong order");
	a_shape_width: assert property (
		state == lcd_cmd_pkg::ST_SHAPE_W && param_take
		|=> CURSOR_WIDTH_O == $past(BYTE_DATA_I[3:0]))
		else $error("cursor width not taken from first parameter");
	a_shape_height: assert property (
		state == lcd_cmd_pkg::ST_SHAPE_H && param_take
		|=> CURSOR_HEIGHT_O == $past(BYTE_DATA_I[3:0]))
		else $error("cursor height not taken from second parameter");
	a_shape_style: assert property (
		state == lcd_cmd_pkg::ST_SHAPE_H && param_take
		|=> CURSOR_BLOCK_O == $past(BYTE_DATA_I[7]))
		else $error("cursor style bit not taken");
	a_dir_right: assert property (
		cmd_take && hb.data == lcd_cmd_pkg::CMD_DIR_BASE
		|=> SHIFT_DIR_O == lcd_cmd_pkg::DIR_RIGHT)
		else $error("right shift not selected by 4Ch");
	a_dir_down_step: assert property (
		mem_we && dir == lcd_cmd_pkg::DIR_DOWN
		|=> CURSOR_ADDR_O == $past(CURSOR_ADDR_O) + $past(LINE_PITCH_I))
		else $error("downward write did not advance one line");
	a_write_right_step: assert property (
		mem_we && dir == lcd_cmd_pkg::DIR_RIGHT
		|=> CURSOR_ADDR_O ==
		$past(CURSOR_ADDR_O) + lcd_cmd_pkg::ONE_STEP)
		else $error("rightward write did not advance by one");
	a_start_pairs: assert property (
		BLOCK1_START_O == lcd_cmd_pkg::BLOCK1_START_RESET &&
		BLOCK2_START_O == lcd_cmd_pkg::BLOCK2_START_RESET)
		else $error("block start addresses lost their values");
	// A write command may follow at once, so only the next cycle is fixed.
	a_new_cmd_ends: assert property (
		cmd_take && hb.data == lcd_cmd_pkg::CMD_DIR_BASE
		|=> state == lcd_cmd_pkg::ST_IDLE && !mem_we)
		else $error("parameter run not ended by new command");

	c_display_on: cover property (cmd_take &&
		hb.data == lcd_cmd_pkg::CMD_DISP_ON);
	c_cursor_load: cover property (state == lcd_cmd_pkg::ST_CURSOR_HI
		&& param_take);
	c_write_run: cover property (mem_we ##2 mem_we ##2 mem_we);
	c_shape_block: cover property (state == lcd_cmd_pkg::ST_SHAPE_H
		&& param_take && BYTE_DATA_I[7]);
endmodule : lcd_cmd_decoder

// file: include/lcd_cmd_pkg.sv
/*
 * Shared constants and types of the LCD command decoder: command codes,
 * register offsets, field positions, reset values and carrier structs.
 * Assumes a single 40 MHz clock domain for every user of the package.
 */
// Summary of operation
// - Command 58h clears display enable bit 0; 59h sets it.
// - First display switch parameter goes to attribute register; bits 1-0 cursor flash.
// - Attribute bits 3-2, 5-4, 7-6 set block visibility; 01 shows block.
// - Cursor load 46h takes low address byte, then high address byte.
// - Shape command 5Dh stores first parameter bits 3-0 as width minus one.
// - Shape command stores second parameter bits 3-0 as height minus one.
// - Second shape parameter bit 7 set selects a block cursor.
// - Direction command has no parameter; 4Ch selects right shift in bits 1-0.
// - Direction code 4Fh selects downward shift, one display line per write.
// - Memory write 42h stores each parameter at cursor, then steps cursor.
// - Block start addresses are 16-bit register pairs, 0000h and 1000h.
package lcd_cmd_pkg;
	localparam logic [7:0] CMD_DISP_OFF = 8'h58;
	localparam logic [7:0] CMD_DISP_ON = 8'h59;
	localparam logic [7:0] CMD_CURSOR_LOAD = 8'h46;
	localparam logic [7:0] CMD_CURSOR_SHAPE = 8'h5d;
	localparam logic [7:0] CMD_MEM_WRITE = 8'h42;
	localparam logic [7:0] CMD_DIR_BASE = 8'h4c;
	localparam logic [7:0] CMD_DIR_MASK = 8'hfc;

	localparam logic [7:0] OFS_DISP_ENABLE = 8'h09;
	localparam logic [7:0] OFS_ATTRIBUTE = 8'h0a;
	localparam logic [7:0] OFS_BLOCK1_LO = 8'h0b;
	localparam logic [7:0] OFS_BLOCK1_HI = 8'h0c;
	localparam logic [7:0] OFS_BLOCK2_LO = 8'h0e;
	localparam logic [7:0] OFS_BLOCK2_HI = 8'h0f;
	localparam logic [7:0] OFS_CURSOR_WIDTH = 8'h15;
	localparam logic [7:0] OFS_CURSOR_HEIGHT = 8'h16;
	localparam logic [7:0] OFS_SHIFT_DIR = 8'h17;
	localparam logic [7:0] OFS_CURSOR_LO = 8'h1c;
	localparam logic [7:0] OFS_CURSOR_HI = 8'h1d;

	localparam int DISP_ENABLE_BIT = 0;
	localparam int CURSOR_STYLE_BIT = 7;
	localparam int SIZE_W = 4;
	localparam int MEM_AW = 16;

	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [15:0] CURSOR_RESET = 16'h0000;
	localparam logic [15:0] BLOCK1_START_RESET = 16'h0000;
	localparam logic [15:0] BLOCK2_START_RESET = 16'h1000;
	localparam logic [15:0] ONE_STEP = 16'h0001;

	localparam logic [1:0] DIR_RIGHT = 2'h0;
	localparam logic [1:0] DIR_LEFT = 2'h1;
	localparam logic [1:0] DIR_UP = 2'h2;
	localparam logic [1:0] DIR_DOWN = 2'h3;

	typedef struct packed {
		logic is_cmd;
		logic [7:0] data;
	} host_byte_t;

	typedef struct packed {
		logic [SIZE_W-1:0] width;
		logic [SIZE_W-1:0] height;
		logic block_style;
	} cursor_shape_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SWITCH_P1,
		ST_CURSOR_LO,
		ST_CURSOR_HI,
		ST_SHAPE_W,
		ST_SHAPE_H,
		ST_MEM_WRITE
	} dec_state_t;
endpackage : lcd_cmd_pkg

// file: tb/host_model.sv
/*
 * Host model: issues command and parameter bytes to the LCD decoder.
 * Assumes the decoder takes a byte on a rising edge with valid high.
 */
module host_model (
	input wire logic clk_i,
	output logic byte_valid_o,
	output logic byte_is_cmd_o,
	output logic [7:0] byte_data_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		byte_valid_o = 1'b0;
		byte_is_cmd_o = 1'b0;
		byte_data_o = 8'h00;
	end

	// Between bytes the lines carry the inverse of the last byte, so a
	// decoder that samples without the strobe picks up garbage.
	task automatic put(input logic c, input logic [7:0] d);
		@(posedge clk_i);
		byte_valid_o <= 1'b1;
		byte_is_cmd_o <= c;
		byte_data_o <= d;
		@(posedge clk_i);
		byte_valid_o <= 1'b0;
		byte_is_cmd_o <= ~c;
		byte_data_o <= ~d;
	endtask : put

	task automatic cursor(input logic [15:0] a);
		put(1'b1, lcd_cmd_pkg::CMD_CURSOR_LOAD);
		put(1'b0, a[7:0]);
		put(1'b0, a[15:8]);
	endtask : cursor

	task automatic fill(input logic [15:0] a, input int n,
		input logic [7:0] d);
		cursor(a);
		put(1'b1, 8'h4c);
		put(1'b1, lcd_cmd_pkg::CMD_MEM_WRITE);
		repeat (n) put(1'b0, d);
	endtask : fill

	// Only the first n positions of each layer are cleared, which keeps
	// the run short at the cost of leaving the rest of memory unknown.
	task automatic init_display(input int n);
		put(1'b1, lcd_cmd_pkg::CMD_DISP_OFF);
		put(1'b0, 8'h56);
		fill(16'h0000, n, 8'h20);
		fill(16'h1000, n, 8'h00);
		cursor(16'h0000);
		put(1'b1, lcd_cmd_pkg::CMD_CURSOR_SHAPE);
		put(1'b0, 8'h04);
		put(1'b0, 8'h86);
		put(1'b1, lcd_cmd_pkg::CMD_DISP_ON);
		put(1'b0, 8'h16);
	endtask : init_display
endmodule : host_model

// file: tb/tb_top.sv
/*
 * Self-checking bench of the LCD command decoder with a host byte model.
 * Assumes the package, display memory and decoder are compiled first.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] scan_addr = 16'h0000;
	logic [15:0] pitch = 16'h0028;
	logic valid, is_cmd, en, blk;
	logic [7:0] data, reg_data, attr, scan_data;
	logic [15:0] csr, b1, b2;
	logic [3:0] wid, hgt;
	logic [1:0] dir;
	int miscompares = 0;
	int checked = 0;
	logic [7:0] text [3] = '{8'h44, 8'h6f, 8'h74};

	host_model host (.clk_i(clk), .byte_valid_o(valid),
		.byte_is_cmd_o(is_cmd), .byte_data_o(data));

	lcd_cmd_decoder dut (.REF_CLK_I(clk), .RST_N_I(rst_n),
		.BYTE_VALID_I(valid), .BYTE_IS_CMD_I(is_cmd), .BYTE_DATA_I(data),
		.LINE_PITCH_I(pitch), .REG_RD_I(reg_rd), .REG_ADDR_I(reg_addr),
		.SCAN_ADDR_I(scan_addr), .REG_DATA_O(reg_data), .DISP_ENABLE_O(en),
		.ATTR_O(attr), .CURSOR_ADDR_O(csr), .CURSOR_WIDTH_O(wid),
		.CURSOR_HEIGHT_O(hgt), .CURSOR_BLOCK_O(blk), .SHIFT_DIR_O(dir),
		.BLOCK1_START_O(b1), .BLOCK2_START_O(b2), .SCAN_DATA_O(scan_data));

	initial begin
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time,
				seen, exp);
		end
	endtask : chk

	task automatic settle();
		repeat (2) @(negedge clk);
	endtask : settle

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge clk);
		@(negedge clk);
		chk({8'h00, reg_data}, {8'h00, exp});
	endtask : rd

	// Memory data come out one cycle after the address; two are allowed.
	task automatic scan(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		scan_addr <= a;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk({8'h00, scan_data}, {8'h00, exp});
	endtask : scan

	task automatic complete_run();
		$display("Checks %0d, miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		complete_run();
	end

	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		settle();
		chk(b1, 16'h0000);
		chk(b2, 16'h1000);
		rd(8'h0f, 8'h10);
		rd(8'h17, 8'h00);
		rd(8'h30, 8'h00);
		host.init_display(4);
		settle();
		chk({15'h0000, en}, 16'h0001);
		chk({8'h00, attr}, 16'h0016);
		chk({12'h000, wid}, 16'h0004);
		chk({12'h000, hgt}, 16'h0006);
		chk({15'h0000, blk}, 16'h0001);
		rd(8'h16, 8'h86);
		scan(16'h0003, 8'h20);
		scan(16'h1003, 8'h00);
		host.put(1'b1, 8'h58);
		host.put(1'b0, 8'h56);
		settle();
		chk({15'h0000, en}, 16'h0000);
		rd(8'h0a, 8'h56);
		rd(8'h09, 8'h00);
		for (int i = 0; i < 4; i++) begin
			host.put(1'b1, 8'h4c + 8'(i));
			settle();
			chk({14'h0000, dir}, 16'(i));
		end
		host.cursor(16'h1001);
		settle();
		chk(csr, 16'h1001);
		rd(8'h1c, 8'h01);
		rd(8'h1d, 8'h10);
		host.put(1'b1, 8'h42);
		repeat (3) host.put(1'b0, 8'hff);
		settle();
		chk(csr, 16'h1079);
		scan(16'h1029, 8'hff);
		scan(16'h1051, 8'hff);
		host.cursor(16'h0100);
		host.put(1'b1, 8'h4c);
		host.put(1'b1, 8'h42);
		foreach (text[i]) host.put(1'b0, text[i]);
		settle();
		chk(csr, 16'h0103);
		scan(16'h0102, 8'h74);
		host.put(1'b1, 8'h5d);
		host.put(1'b0, 8'h07);
		host.put(1'b1, 8'h4c);
		host.put(1'b0, 8'h0f);
		settle();
		chk({12'h000, wid}, 16'h0007);
		rd(8'h16, 8'h86);
		chk(csr, 16'h0103);
		rd(8'h15, 8'h07);
		// Leftward and upward runs: the cursor steps back by one and by
		// one line pitch.
		host.put(1'b1, 8'h4d);
		host.put(1'b1, 8'h42);
		repeat (2) host.put(1'b0, 8'h55);
		settle();
		chk(csr, 16'h0101);
		scan(16'h0102, 8'h55);
		host.put(1'b1, 8'h4e);
		host.put(1'b1, 8'h42);
		host.put(1'b0, 8'h33);
		settle();
		chk(csr, 16'h00d9);
		scan(16'h0101, 8'h33);
		rd(8'h1d, 8'h00);
		// A second reset in mid-run must bring every register back.
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		settle();
		chk(csr, 16'h0000);
		chk({14'h0000, dir}, 16'h0000);
		chk({15'h0000, en}, 16'h0000);
		rd(8'h15, 8'h00);
		rd(8'h0a, 8'h00);
		rd(8'h0e, 8'h00);
		chk(b2, 16'h1000);
		complete_run();
	end
endmodule : tb_top
